/* File: core/ocs_pkg.sv */
package ocs_pkg;

  // ==========================================================
  // Timing.
  localparam int CLK_NS = 40;
  localparam int REF_LOSS_NS = 10000;
  // A longest wait rounds down to whole cycles.
  localparam int REF_LOSS_CYC = REF_LOSS_NS / CLK_NS;
  localparam int FACT_SETTLE = 3;

  // ==========================================================
  // Frequency plan.
  localparam int PLL_MULT = 8;
  localparam int MAX_SYS_KHZ = 32000;
  localparam int NOM_ROSC_KHZ = 8000;
  localparam int PSC_W = 3;
  localparam int TRIM_W = 10;
  localparam logic [PSC_W-1:0] PSC_MAX_CODE = 3'h5;

  // ==========================================================
  // Register map, byte addresses.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_DIVBY = 8'h04;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] A_OCTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] A_FACT = 8'h10;
  localparam logic [ADDR_W-1:0] A_ISTAT = 8'h14;
  localparam logic [ADDR_W-1:0] A_IMASK = 8'h18;

  // Control register fields.
  localparam int CTRL_W = 7;
  localparam int CTRL_REFSEL = 0;
  localparam int CTRL_PLLSEL = 1;
  localparam int CTRL_PLLPD = 2;
  localparam int CTRL_STBY = 3;
  localparam int CTRL_OSCPD = 4;
  localparam int CTRL_XTALPD = 5;
  localparam int CTRL_EXTPIN = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // Status register fields.
  localparam int STAT_W = 4;
  localparam int ST_LOCK = 0;
  localparam int ST_LOST = 1;
  localparam int ST_PLL = 2;
  localparam int ST_SHUT = 3;

  // Interrupt events.
  localparam int EV_W = 3;
  localparam int EV_LOST = 0;
  localparam int EV_UNLOCK = 1;
  localparam int EV_LOCK = 2;

  typedef enum logic [2:0] {
    P_DIRECT = 3'b001,
    P_PLL = 3'b010,
    P_SHUT = 3'b100
  } ocs_path_t;

  function automatic logic ocs_psc_legal(input logic [PSC_W-1:0] c);
    return c <= PSC_MAX_CODE;
  endfunction

  // Smallest postscaler code that keeps the system clock in range.
  function automatic int ocs_min_code(input int ref_khz);
    int c;
    c = 0;
    while (c < 5 && ((ref_khz * PLL_MULT / 2) >> c) > MAX_SYS_KHZ)
      c = c + 1;
    return c;
  endfunction

endpackage

/* File: core/ocs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ocs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: core/ocs_div.sv */
`timescale 1ns/1ps
`default_nettype none
module ocs_div
  import ocs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_level,
  input wire logic [PSC_W-1:0] code,
  output logic out_level
);
  logic in_q;
  logic [4:0] cnt;
  logic [4:0] half_m1;
  logic rise;

  assign rise = in_level & ~in_q;
  // Divide by two to the code: toggle after half the input periods.
  assign half_m1 = (code == '0) ? 5'h00 : 5'((5'h01 << (code - 3'h1)) - 5'h01);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_q <= 1'b0;
      cnt <= 5'h00;
      out_level <= 1'b0;
    end else begin
      in_q <= in_level;
      if (code == '0) begin
        out_level <= in_level;
        cnt <= 5'h00;
      end else if (rise) begin
        if (cnt >= half_m1) begin
          cnt <= 5'h00;
          out_level <= ~out_level;
        end else begin
          cnt <= cnt + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/ocs_clock_synth.sv */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Summary of operation
// R1: Direct mode passes the selected reference straight to the 2X clock.
// R2: PLL mode gives reference times eight over a power-of-two postscaler.
// R3: A 3-bit postscaler field selects the divisor on the PLL output.
// R4: System clock is the 2X clock halved, giving a 50% duty cycle.
// R5: The 2X clock is driven out to the system integration unit.
// R6: A 3X clock is driven out to timer and PWM blocks.
// R7: Postscaler is clamped so the system clock never passes 32 MHz.
// R8: Software picks internal, crystal or external clock as reference.
// R9: After reset the internal relaxation oscillator is the reference.
// R10: Software switches to an external source only once it is stable.
// R11: A 10-bit trim value sits in bits 0 to 9 of oscillator control.
// R12: Each trim step moves the oscillator about 0.078% of 8 MHz.
// R13: The factory trim is loaded into the factory option word at reset.
// R14: Boot software copies the factory trim into the trim field.
// R15: Losing the PLL reference triggers a safety shutdown.
// R16: Software can power down the PLL.
// R17: Software can put the oscillators in standby or power them down.
// R18: Postscaler codes 0 to 5 give 1 to 32; codes 6 and 7 are ignored.
// R19: Reference loss sets a readable flag and forces 2X off the PLL path.
module ocs_clock_synth
  import ocs_pkg::*;
#(
  parameter int REF_KHZ = NOM_ROSC_KHZ,
  parameter int LOSS_CYC = REF_LOSS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rosc_clk,
  input wire logic xosc_clk,
  input wire logic ext_clk,
  input wire logic pll_clk,
  input wire logic pll_lock,
  input wire logic tri_clk,
  input wire logic [TRIM_W-1:0] factory_trim,
  output logic clk2x,
  output logic clk_sys,
  output logic clk3x,
  output logic ref_source_select,
  output logic pll_powerdown,
  output logic osc_standby,
  output logic osc_powerdown,
  output logic xtal_powerdown,
  output logic [TRIM_W-1:0] osc_trim,
  output logic ref_lost,
  output logic irq
);
  localparam logic [PSC_W-1:0] MIN_CODE = PSC_W'(ocs_min_code(REF_KHZ));
  localparam logic [11:0] LOSS_LIM = 12'(LOSS_CYC);
  localparam logic [1:0] FACT_DONE = 2'(FACT_SETTLE);

  // ==========================================================
  // Pin synchronisers.
  localparam int SW = 6 + TRIM_W;
  logic [SW-1:0] sync_q;
  logic rosc_s, xosc_s, ext_s, pll_s, lock_s, tri_s;
  logic [TRIM_W-1:0] fact_s;

  ocs_sync #(.W(SW)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({factory_trim, tri_clk, pll_lock, pll_clk, ext_clk, xosc_clk,
        rosc_clk}),
    .q(sync_q)
  );
  assign {fact_s, tri_s, lock_s, pll_s, ext_s, xosc_s, rosc_s} = sync_q;

  // ==========================================================
  // Registers.
  logic [CTRL_W-1:0] ctrl;
  logic [PSC_W-1:0] pscale;
  logic [TRIM_W-1:0] factory_option_word;
  logic [1:0] fact_cnt;
  logic [EV_W-1:0] istat, imask, ev;
  ocs_path_t path, next_path;
  logic wr_en, rd_en, ref_s, ref_q, ref_edge, lock_q;
  logic [11:0] loss_cnt;
  logic [31:0] next_rdata;
  logic next_err;

  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready & ~pwrite;

  always_comb begin
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    case (paddr)
      A_CTRL: next_rdata = 32'(ctrl);
      A_DIVBY: next_rdata = 32'(pscale);
      A_STAT: next_rdata = 32'({path == P_SHUT, path == P_PLL, ref_lost,
                                lock_s});
      A_OCTRL: next_rdata = 32'(osc_trim);
      A_FACT: next_rdata = 32'(factory_option_word);
      A_ISTAT: next_rdata = 32'(istat);
      A_IMASK: next_rdata = 32'(imask);
      default: next_err = 1'b1;
    endcase
  end

  // One wait state; a write lands on the edge that sees pready high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & next_err;
      if (rd_en)
        prdata <= next_rdata;
    end
  end

  // Reset selects the internal oscillator; a shutdown drops the PLL request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST; // R9
    end else begin
      if (wr_en && paddr == A_CTRL)
        ctrl <= pwdata[CTRL_W-1:0]; // R8 R16 R17
      if (path == P_PLL && ref_lost)
        ctrl[CTRL_PLLSEL] <= 1'b0; // R19
    end
  end

  // Reserved codes are dropped; fast codes are raised to the limit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pscale <= PSC_MAX_CODE;
    end else if (wr_en && paddr == A_DIVBY &&
                 ocs_psc_legal(pwdata[PSC_W-1:0])) begin // R18
      if (pwdata[PSC_W-1:0] < MIN_CODE)
        pscale <= MIN_CODE; // R7
      else
        pscale <= pwdata[PSC_W-1:0]; // R3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      osc_trim <= '0;
    else if (wr_en && paddr == A_OCTRL)
      osc_trim <= pwdata[TRIM_W-1:0]; // R11 R12
  end

  // The stored word is only trusted once the synchroniser has settled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fact_cnt <= 2'h0;
      factory_option_word <= '0;
    end else if (fact_cnt != FACT_DONE) begin
      fact_cnt <= fact_cnt + 2'h1;
      if (fact_cnt == FACT_DONE - 2'h1)
        factory_option_word <= fact_s; // R13
    end
  end

  // ==========================================================
  // Reference selection and loss detection.
  always_comb begin
    if (!ctrl[CTRL_REFSEL])
      ref_s = rosc_s;
    else if (ctrl[CTRL_EXTPIN])
      ref_s = ext_s;
    else
      ref_s = xosc_s; // R8
  end
  assign ref_edge = ref_s ^ ref_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
      loss_cnt <= 12'h000;
      ref_lost <= 1'b0;
    end else begin
      ref_q <= ref_s;
      if (ref_edge) begin
        loss_cnt <= 12'h000;
        ref_lost <= 1'b0;
      end else if (loss_cnt != LOSS_LIM) begin
        loss_cnt <= loss_cnt + 12'h001;
      end else begin
        ref_lost <= 1'b1; // R15
      end
    end
  end

  // ==========================================================
  // Clock path state.
  always_comb begin
    next_path = path;
    case (path)
      P_DIRECT:
        if (ctrl[CTRL_PLLSEL] && lock_s && !ctrl[CTRL_PLLPD] && !ref_lost)
          next_path = P_PLL;
      P_PLL:
        if (ref_lost)
          next_path = P_SHUT; // R15 R19
        else if (!ctrl[CTRL_PLLSEL] || ctrl[CTRL_PLLPD] || !lock_s)
          next_path = P_DIRECT;
      P_SHUT:
        if (!ref_lost)
          next_path = P_DIRECT;
      default:
        next_path = P_DIRECT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      path <= P_DIRECT;
    else
      path <= next_path;
  end

  // ==========================================================
  // Clock outputs.
  logic div_q, clk2x_q;

  ocs_div u_div (
    .clk(pclk),
    .rst_n(presetn),
    .in_level(pll_s),
    .code(pscale),
    .out_level(div_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk2x <= 1'b0;
      clk2x_q <= 1'b0;
      clk_sys <= 1'b0;
      clk3x <= 1'b0;
    end else begin
      if (path == P_PLL)
        clk2x <= div_q; // R2 R5
      else
        clk2x <= ref_s; // R1 R5
      clk2x_q <= clk2x;
      if (clk2x && !clk2x_q)
        clk_sys <= ~clk_sys; // R4
      clk3x <= tri_s; // R6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_source_select <= 1'b0;
      pll_powerdown <= 1'b0;
      osc_standby <= 1'b0;
      osc_powerdown <= 1'b0;
      xtal_powerdown <= 1'b0;
    end else begin
      ref_source_select <= ctrl[CTRL_REFSEL]; // R9
      pll_powerdown <= ctrl[CTRL_PLLPD]; // R16
      osc_standby <= ctrl[CTRL_STBY]; // R17
      osc_powerdown <= ctrl[CTRL_OSCPD]; // R17
      xtal_powerdown <= ctrl[CTRL_XTALPD]; // R17
    end
  end

  // ==========================================================
  // Interrupts; a new event beats a same-cycle write-one-to-clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lock_q <= 1'b0;
    else
      lock_q <= lock_s;
  end

  always_comb begin
    ev = '0;
    ev[EV_LOST] = path == P_PLL && ref_lost;
    ev[EV_UNLOCK] = lock_q && !lock_s;
    ev[EV_LOCK] = !lock_q && lock_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat <= '0;
      imask <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == A_ISTAT)
        istat <= (istat & ~pwdata[EV_W-1:0]) | ev;
      else
        istat <= istat | ev; // R19
      if (wr_en && paddr == A_IMASK)
        imask <= pwdata[EV_W-1:0];
      irq <= |(istat & imask);
    end
  end

  // ==========================================================
  // Checks.
  a_direct_follow: assert property (@(posedge pclk) disable iff (!presetn)
    path == P_DIRECT |=> clk2x == $past(ref_s)) // R1
    else $error("2X clock does not follow the reference in direct mode.");
  a_pll_leave: assert property (@(posedge pclk) disable iff (!presetn)
    path == P_PLL && !lock_s |=> path != P_PLL) // R2
    else $error("PLL path kept after lock was lost.");
  a_psc_range: assert property (@(posedge pclk) disable iff (!presetn)
    pscale <= PSC_MAX_CODE && pscale >= MIN_CODE) // R18
    else $error("Postscaler code out of range.");
  a_freq_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == A_DIVBY && pwdata[PSC_W-1:0] < MIN_CODE
    |=> pscale == MIN_CODE) // R7
    else $error("Fast postscaler code was not clamped.");
  a_sys_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(clk_sys) |-> $past(clk2x && !clk2x_q)) // R4
    else $error("System clock toggled without a 2X rising edge.");
  a_trim_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == A_OCTRL |=> osc_trim == $past(pwdata[TRIM_W-1:0])) // R11
    else $error("Trim write not stored.");
  a_fact_load: assert property (@(posedge pclk) disable iff (!presetn)
    fact_cnt == FACT_DONE - 2'h1 |=>
    factory_option_word == $past(fact_s) ##1 fact_cnt == FACT_DONE) // R13
    else $error("Factory trim not captured after reset.");
  a_lost_shut: assert property (@(posedge pclk) disable iff (!presetn)
    path == P_PLL && ref_lost |=> path == P_SHUT && !ctrl[CTRL_PLLSEL]
    && istat[EV_LOST] ##1 clk2x == $past(ref_s)) // R19
    else $error("Reference loss did not force the PLL path off.");
  a_pd_follow: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == A_CTRL |=> ##1 pll_powerdown ==
    $past(pwdata[CTRL_PLLPD], 2)) // R16
    else $error("PLL power-down did not follow the control write.");
  a_shut_loss: assert property (@(posedge pclk) disable iff (!presetn)
    !ref_edge [*8] ##1 loss_cnt == LOSS_LIM && !ref_edge
    |=> ref_lost) // R15
    else $error("Reference loss not flagged after the timeout.");

  c_pll_run: cover property (@(posedge pclk) disable iff (!presetn)
    path == P_DIRECT ##1 path == P_PLL);
  c_shutdown: cover property (@(posedge pclk) disable iff (!presetn)
    path == P_SHUT);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
  c_reserved: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == A_DIVBY && !ocs_psc_legal(pwdata[PSC_W-1:0]));
endmodule
`default_nettype wire

/* File: test/ocs_clk_src.sv */
`timescale 1ns/1ps
`default_nettype none
module ocs_clk_src (
  input wire logic osc_powerdown,
  input wire logic xtal_powerdown,
  input wire logic pll_powerdown,
  input wire logic stop_rosc,
  output var logic rosc_clk,
  output var logic xosc_clk,
  output var logic ext_clk,
  output var logic pll_clk,
  output var logic pll_lock,
  output var logic tri_clk
);
  // ==========================================================
  // Sources
  // Rates are scaled so every pin stays under a quarter of pclk.
  initial begin
    rosc_clk = 1'b0;
    xosc_clk = 1'b0;
    ext_clk = 1'b0;
    pll_clk = 1'b0;
    tri_clk = 1'b0;
  end
  // A stopped source stands still, which is what a loss looks like.
  always begin
    #800;
    if (!osc_powerdown && !stop_rosc) rosc_clk = ~rosc_clk;
  end
  always begin
    #1000;
    if (!xtal_powerdown) xosc_clk = ~xosc_clk;
  end
  always begin
    #1200;
    ext_clk = ~ext_clk;
  end
  always begin
    #100;
    if (!pll_powerdown) pll_clk = ~pll_clk;
  end
  always begin
    #280;
    tri_clk = ~tri_clk;
  end
  always_comb pll_lock = !pll_powerdown;
endmodule
`default_nettype wire

/* File: test/on_chip_clock_synthesis_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module on_chip_clock_synthesis_tb import ocs_pkg::*;;
  localparam int RKHZ = 16000;
  localparam int LOSS = 64;
  localparam logic [6:0] CV [7] = '{7'h01, 7'h41, 7'h02, 7'h04, 7'h08,
    7'h10, 7'h20};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, e, seed;
  logic stop_rosc, rosc_clk, xosc_clk, ext_clk, pll_clk, pll_lock, tri_clk;
  logic [TRIM_W-1:0] factory_trim, osc_trim;
  logic clk2x, clk_sys, clk3x, ref_source_select, pll_powerdown;
  logic osc_standby, osc_powerdown, xtal_powerdown, ref_lost, irq;
  logic [7:0] smp, prv;
  int failures, comparisons, cyc, mc;
  int cnt [8];
  int d [8];

  ocs_clock_synth #(.REF_KHZ(RKHZ), .LOSS_CYC(LOSS)) i_ocs_clock_synth (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rosc_clk, .xosc_clk, .ext_clk, .pll_clk, .pll_lock,
    .tri_clk, .factory_trim, .clk2x, .clk_sys, .clk3x, .ref_source_select,
    .pll_powerdown, .osc_standby, .osc_powerdown, .xtal_powerdown,
    .osc_trim, .ref_lost, .irq);
  ocs_clk_src i_ocs_clk_src (.osc_powerdown, .xtal_powerdown,
    .pll_powerdown, .stop_rosc, .rosc_clk, .xosc_clk, .ext_clk, .pll_clk,
    .pll_lock, .tri_clk);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ==========================================================
  // Edge counters and hang guard
  assign smp = {ext_clk, xosc_clk, clk2x, clk_sys, clk3x, rosc_clk, pll_clk,
                tri_clk};
  always @(posedge pclk) begin
    prv <= smp;
    for (int i = 0; i < 8; i++) if (smp[i] && !prv[i]) cnt[i] <= cnt[i] + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      summarize();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // The system clock is half of 2X, so the smallest code must keep ref*4 in range.
  function automatic int min_code(input int khz);
    int c;
    c = 0;
    while (c < 5 && ((khz * 4) >> c) > MAX_SYS_KHZ) c++;
    return c;
  endfunction
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] g);
    comparisons++;
    if (g !== ex) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, ex, g);
    end
  endtask
  // Edge counts of unrelated clocks may differ by one at the window ends.
  task automatic near(input string nm, input int ex, input int g);
    comparisons++;
    if (g < ex - 1 || g > ex + 1) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", nm, ex, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex,
                       input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask
  task automatic measure(input int n);
    int c0 [8];
    c0 = cnt;
    repeat (n) @(posedge pclk);
    for (int i = 0; i < 8; i++) d[i] = cnt[i] - c0[i];
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h7453;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stop_rosc = 1'b0;
    failures = 0;
    comparisons = 0;
    cyc = 0;
    prv = 8'h00;
    for (int i = 0; i < 8; i++) cnt[i] = 0;
    v = rnd();
    factory_trim = v[9:0];
    mc = min_code(RKHZ);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rdchk(A_CTRL, 32'h0, "ctrl_rst");
    chk("ref_sel_rst", 32'h0, {31'h0, ref_source_select});
    rdchk(A_DIVBY, 32'h5, "divby_rst");
    rdchk(A_FACT, {22'h0, factory_trim}, "factory");
    rdchk(A_OCTRL, 32'h0, "trim_rst");
    rdchk(A_IMASK, 32'h0, "imask_rst");
    wr(8'h1c, 32'hffff_ffff);
    chk("wr_err", 32'h1, {31'h0, err});
    rdchk(8'h1c, 32'h0, "unmapped");
    chk("rd_err", 32'h1, {31'h0, err});
    // Boot code first copies the factory word into the trim field.
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? {22'h0, factory_trim} : rnd();
      wr(A_OCTRL, v);
      rdchk(A_OCTRL, v & 32'h3ff, "trim");
      chk("osc_trim", v & 32'h3ff, {22'h0, osc_trim});
    end
    // The crystal already runs, so switching to it is safe.
    foreach (CV[i]) begin
      wr(A_CTRL, {25'h0, CV[i]});
      rdchk(A_CTRL, {25'h0, CV[i]}, "ctrl");
      v = {27'h0, xtal_powerdown, osc_powerdown, osc_standby,
           pll_powerdown, ref_source_select};
      chk("ctrl_pins", {27'h0, CV[i][5:2], CV[i][0]}, v);
    end
    e = 32'h5;
    for (int c = 0; c < 8; c++) begin
      wr(A_DIVBY, 32'(c));
      if (c <= 5) e = (c < mc) ? 32'(mc) : 32'(c);
      rdchk(A_DIVBY, e, "divby");
    end
    wr(A_CTRL, 32'h0);
    repeat (20) @(posedge pclk);
    measure(400);
    near("direct_2x", d[2], d[5]);
    near("sys_clk", d[5] / 2, d[4]);
    near("clk3x", d[0], d[3]);
    // Both external sources already run, so either may be picked.
    wr(A_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    measure(400);
    near("xtal_2x", d[6], d[5]);
    wr(A_CTRL, 32'h41);
    repeat (20) @(posedge pclk);
    measure(400);
    near("ext_2x", d[7], d[5]);
    wr(A_CTRL, 32'h2);
    for (int c = mc; c < 6; c++) begin
      wr(A_DIVBY, 32'(c));
      repeat (20) @(posedge pclk);
      measure(800);
      near("pll_2x", d[1] >> c, d[5]);
      near("pll_sys", d[5] / 2, d[4]);
    end
    rdchk(A_STAT, 32'h5, "stat_pll");
    wr(A_ISTAT, 32'h7);
    wr(A_IMASK, 32'h1);
    stop_rosc <= 1'b1;
    repeat (LOSS + 40) @(posedge pclk);
    chk("ref_lost", 32'h1, {31'h0, ref_lost});
    rdchk(A_STAT, 32'hb, "stat_shut");
    rdchk(A_CTRL, 32'h0, "ctrl_shut");
    rdchk(A_ISTAT, 32'h1, "istat_lost");
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(A_IMASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    stop_rosc <= 1'b0;
    repeat (60) @(posedge pclk);
    chk("ref_back", 32'h0, {31'h0, ref_lost});
    rdchk(A_STAT, 32'h1, "stat_back");
    wr(A_IMASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_sticky", 32'h1, {31'h0, irq});
    wr(A_ISTAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wr(A_ISTAT, 32'h7);
    wr(A_CTRL, 32'h6);
    repeat (10) @(posedge pclk);
    rdchk(A_STAT, 32'h0, "stat_pd");
    rdchk(A_ISTAT, 32'h2, "istat_unlock");
    wr(A_CTRL, 32'h0);
    repeat (10) @(posedge pclk);
    rdchk(A_ISTAT, 32'h6, "istat_lock");
    summarize();
  end
endmodule
`default_nettype wire
